// File: crm_pkg.sv
package crm_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [31:0] EXT_REMAP_ADDR     = 32'h1A0C_0040;
   localparam logic [31:0] ONCHIP_REMAP_ADDR  = 32'h1A0C_0044;
   localparam logic [31:0] EXT_ACTIVE_ADDR    = 32'h1A0C_0058;
   localparam logic [31:0] ONCHIP_ACTIVE_ADDR = 32'h1A0C_005C;

   // ************************************************************
   // field layout
   // ************************************************************
   localparam int BASE_LSB   = 16;
   localparam int BASE_W     = 16;
   localparam int SHIFT_LSB  = 4;
   localparam int SHIFT_W    = 12;
   localparam int RSVD_BIT   = 3;
   localparam int SPAN_LSB   = 0;
   localparam int SPAN_W     = 3;
   localparam int WORD_LSB   = 2;

   // ************************************************************
   // reset values and fixed bits
   // ************************************************************
   localparam logic [15:0] EXT_BASE_RST    = 16'h1600;
   localparam logic [15:0] ONCHIP_BASE_RST = 16'h00A0;
   localparam logic [11:0] SHIFT_RST       = 12'h000;
   localparam logic [2:0]  EXT_SPAN_RST    = 3'h6;
   localparam logic [2:0]  ONCHIP_SPAN_RST = 3'h6;
   // external base: address bits 31:25 fixed (address 0x16xx_xxxx or 0x17xx_xxxx), 17:16 zero
   localparam logic [15:0] EXT_BASE_FIX_MASK  = 16'hFE03;
   localparam logic [15:0] EXT_BASE_FIX_VAL   = 16'h1600;
   // on-chip base: address bits 31:24 zero
   localparam logic [15:0] ONCHIP_BASE_FIX_MASK = 16'hFF00;
   localparam logic [15:0] ONCHIP_BASE_FIX_VAL  = 16'h0000;

   // ************************************************************
   // region spans as log2 of bytes, and the lowest valid on-chip span code
   // ************************************************************
   localparam logic [4:0] EXT_SPAN_LOG2_MAX    = 5'h19;
   localparam logic [4:0] ONCHIP_SPAN_LOG2_MAX = 5'h13;
   localparam logic [2:0] ONCHIP_SPAN_CODE_MIN = 3'h4;

   // ************************************************************
   // bus answers
   // ************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: crm_window_xlat.sv
`timescale 1ns/100ps
`default_nettype none

module crm_window_xlat (
   input  wire logic [31:0] addr,
   input  wire logic [15:0] base_hi,
   input  wire logic [4:0]  span_log2,
   input  wire logic [11:0] word_shift,
   output logic             hit,
   output logic [31:0]      xlat
);

   logic [31:0] span_mask;
   logic [31:0] base_addr;
   logic [11:0] shifted_word;

   assign span_mask    = (32'h0000_0001 << span_log2) - 32'h0000_0001;
   assign base_addr    = {base_hi, 16'h0000};
   // hit when the address matches base in every bit above the span, i.e. inside the span-aligned block holding base
   assign hit          = (addr & ~span_mask) == (base_addr & ~span_mask);
   // word offset wraps inside the 12-bit field, carries never reach bit 14
   assign shifted_word = addr[13:2] + word_shift;
   assign xlat         = hit ? {addr[31:14], shifted_word, addr[1:0]} : addr;

endmodule

`default_nettype wire

// File: crm_remap_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

// Function
// - external base field holds address bits 31:16
// - external base bits 31:25, 17:16 fixed
// - external word shift added to bits 13:2
// - external span code: 32 MB halving, reset 6
// - new settings apply only after software reset
// - remap fields survive software resets and retention states
// - on-chip base reset 0x00A0, bits 31:24 zero
// - on-chip word shift added to bits 13:2
// - on-chip span 512k..64k, reset 6
module crm_remap_ctrl
   import crm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        power_on_reset,
   // axi4-lite slave
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // fetch side from the core
   input  wire logic        fetch_valid,
   input  wire logic [31:0] fetch_addr,
   // memory side towards the flashes
   output logic             mem_valid,
   output logic [31:0]      mem_addr,
   output logic             mem_hit_ext,
   output logic             mem_hit_onchip
);

   // ************************************************************
   // programmed (retained) settings
   // ************************************************************
   // these flops have no software reset term: only power-on clears them,
   // so they also ride through retention states untouched
   logic [15:0] ext_base_q,      ext_base_d;
   logic [11:0] ext_shift_q,     ext_shift_d;
   logic [2:0]  ext_span_q,      ext_span_d;
   logic [15:0] onchip_window_base_q;
   logic [15:0] onchip_window_base_d;
   logic [11:0] onchip_window_word_shift_q;
   logic [11:0] onchip_window_word_shift_d;
   logic [2:0]  onchip_window_span_q;
   logic [2:0]  onchip_window_span_d;

   // ************************************************************
   // active mapping, loaded at software reset
   // ************************************************************
   logic [15:0] act_ext_base_q;
   logic [11:0] act_ext_shift_q;
   logic [2:0]  act_ext_span_q;
   logic [15:0] act_on_base_q;
   logic [11:0] act_on_shift_q;
   logic [2:0]  act_on_span_q;

   // ************************************************************
   // bus state
   // ************************************************************
   logic        awready_q;
   logic        wready_q;
   logic        aw_held_q;
   logic        w_held_q;
   logic [31:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        arready_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;

   // ************************************************************
   // fetch path registers
   // ************************************************************
   logic        mem_valid_q;
   logic [31:0] mem_addr_q;
   logic        mem_hit_ext_q;
   logic        mem_hit_onchip_q;

   // ************************************************************
   // write decode
   // ************************************************************
   logic        aw_fire;
   logic        w_fire;
   logic        do_write;
   logic        b_fire;
   logic        wr_ext;
   logic        wr_on;
   logic        wr_ok;
   logic [31:0] strb_mask;
   logic [31:0] ext_word;
   logic [31:0] on_word;
   logic [31:0] ext_merged;
   logic [31:0] on_merged;

   assign aw_fire  = s_axi_awvalid & awready_q;
   assign w_fire   = s_axi_wvalid & wready_q;
   assign do_write = aw_held_q & w_held_q & ~bvalid_q;
   assign b_fire   = bvalid_q & s_axi_bready;
   assign wr_ext   = aw_addr_q == EXT_REMAP_ADDR;
   assign wr_on    = aw_addr_q == ONCHIP_REMAP_ADDR;
   assign wr_ok    = wr_ext | wr_on;

   assign strb_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

   assign ext_word = {ext_base_q, ext_shift_q, 1'b0, ext_span_q};
   assign on_word  = {onchip_window_base_q, onchip_window_word_shift_q, 1'b0, onchip_window_span_q};

   assign ext_merged = (ext_word & ~strb_mask) | (w_data_q & strb_mask);
   assign on_merged  = (on_word & ~strb_mask) | (w_data_q & strb_mask);

   // fixed base bits are forced whatever software writes
   assign ext_base_d = (ext_merged[BASE_LSB +: BASE_W] & ~EXT_BASE_FIX_MASK)
                       | EXT_BASE_FIX_VAL;
   assign ext_shift_d = ext_merged[SHIFT_LSB +: SHIFT_W];
   assign ext_span_d  = ext_merged[SPAN_LSB +: SPAN_W];

   assign onchip_window_base_d = (on_merged[BASE_LSB +: BASE_W] & ~ONCHIP_BASE_FIX_MASK)
                                 | ONCHIP_BASE_FIX_VAL;
   assign onchip_window_word_shift_d = on_merged[SHIFT_LSB +: SHIFT_W];
   assign onchip_window_span_d       = on_merged[SPAN_LSB +: SPAN_W];

   // ************************************************************
   // read decode
   // ************************************************************
   logic        ar_fire;
   logic        r_fire;
   logic        rd_hit;
   logic [31:0] rd_word;
   logic [31:0] act_ext_word;
   logic [31:0] act_on_word;

   assign ar_fire = s_axi_arvalid & arready_q;
   assign r_fire  = rvalid_q & s_axi_rready;

   assign act_ext_word = {act_ext_base_q, act_ext_shift_q, 1'b0, act_ext_span_q};
   assign act_on_word  = {act_on_base_q, act_on_shift_q, 1'b0, act_on_span_q};

   // bit 3 is a constant zero in every word built above
   assign rd_hit = (s_axi_araddr == EXT_REMAP_ADDR) | (s_axi_araddr == ONCHIP_REMAP_ADDR)
                   | (s_axi_araddr == EXT_ACTIVE_ADDR) | (s_axi_araddr == ONCHIP_ACTIVE_ADDR);
   assign rd_word = (s_axi_araddr == EXT_REMAP_ADDR)     ? ext_word     :
                    (s_axi_araddr == ONCHIP_REMAP_ADDR)  ? on_word      :
                    (s_axi_araddr == EXT_ACTIVE_ADDR)    ? act_ext_word :
                    (s_axi_araddr == ONCHIP_ACTIVE_ADDR) ? act_on_word  :
                    32'h0000_0000;

   // ************************************************************
   // span decode of the active mapping
   // ************************************************************
   logic [4:0] ext_span_log2;
   logic [4:0] on_span_log2;

   // 32 MB at code 0, halving per step down to 0.25 MB at code 7
   assign ext_span_log2 = EXT_SPAN_LOG2_MAX - {2'b00, act_ext_span_q};
   // codes below 4 are reserved and behave as 512 kB
   assign on_span_log2  = (act_on_span_q < ONCHIP_SPAN_CODE_MIN) ? ONCHIP_SPAN_LOG2_MAX :
                          ONCHIP_SPAN_LOG2_MAX
                          - ({2'b00, act_on_span_q} - {2'b00, ONCHIP_SPAN_CODE_MIN});

   // ************************************************************
   // translation
   // ************************************************************
   logic        ext_hit;
   logic [31:0] ext_xlat;
   logic        on_hit;
   logic [31:0] on_xlat;
   logic [31:0] fetch_out;

   crm_window_xlat u_ext_win (
      .addr       (fetch_addr),
      .base_hi    (act_ext_base_q),
      .span_log2  (ext_span_log2),
      .word_shift (act_ext_shift_q),
      .hit        (ext_hit),
      .xlat       (ext_xlat)
   );

   crm_window_xlat u_on_win (
      .addr       (fetch_addr),
      .base_hi    (act_on_base_q),
      .span_log2  (on_span_log2),
      .word_shift (act_on_shift_q),
      .hit        (on_hit),
      .xlat       (on_xlat)
   );

   // windows cannot overlap given the fixed base bits; external checked first
   assign fetch_out = ext_hit ? ext_xlat :
                      on_hit  ? on_xlat  :
                      fetch_addr;

   // ************************************************************
   // programmed registers
   // ************************************************************
   always_ff @(posedge clk) begin
      if (power_on_reset) begin
         ext_base_q                 <= EXT_BASE_RST;
         ext_shift_q                <= SHIFT_RST;
         ext_span_q                 <= EXT_SPAN_RST;
         onchip_window_base_q       <= ONCHIP_BASE_RST;
         onchip_window_word_shift_q <= SHIFT_RST;
         onchip_window_span_q       <= ONCHIP_SPAN_RST;
      end else if (do_write & wr_ext) begin
         // software reset does not touch these
         ext_base_q  <= ext_base_d;
         ext_shift_q <= ext_shift_d;
         ext_span_q  <= ext_span_d;
      end else if (do_write & wr_on) begin
         onchip_window_base_q       <= onchip_window_base_d;
         onchip_window_word_shift_q <= onchip_window_word_shift_d;
         onchip_window_span_q       <= onchip_window_span_d;
      end
   end

   // ************************************************************
   // active mapping
   // ************************************************************
   // a write changes only the programmed copy; the fetch path keeps
   // the old mapping until the next software reset loads it here
   always_ff @(posedge clk) begin
      if (power_on_reset) begin
         act_ext_base_q  <= EXT_BASE_RST;
         act_ext_shift_q <= SHIFT_RST;
         act_ext_span_q  <= EXT_SPAN_RST;
         act_on_base_q   <= ONCHIP_BASE_RST;
         act_on_shift_q  <= SHIFT_RST;
         act_on_span_q   <= ONCHIP_SPAN_RST;
      end else if (reset) begin
         act_ext_base_q  <= ext_base_q;
         act_ext_shift_q <= ext_shift_q;
         act_ext_span_q  <= ext_span_q;
         act_on_base_q   <= onchip_window_base_q;
         act_on_shift_q  <= onchip_window_word_shift_q;
         act_on_span_q   <= onchip_window_span_q;
      end
   end

   // ************************************************************
   // write channels
   // ************************************************************
   always_ff @(posedge clk) begin
      if (reset | power_on_reset) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         aw_addr_q <= 32'h0000_0000;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         awready_q <= ~aw_held_q & ~aw_fire & ~bvalid_q & ~do_write;
         wready_q  <= ~w_held_q & ~w_fire & ~bvalid_q & ~do_write;
         if (aw_fire) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_fire) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
         end else if (b_fire) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ************************************************************
   // read channel
   // ************************************************************
   always_ff @(posedge clk) begin
      if (reset | power_on_reset) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= RESP_OKAY;
      end else if (ar_fire) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_word;
         rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (r_fire) begin
         rvalid_q  <= 1'b0;
      end else begin
         arready_q <= ~rvalid_q;
      end
   end

   // ************************************************************
   // fetch path
   // ************************************************************
   // one register stage keeps the outputs glitch free at the cost of a cycle
   always_ff @(posedge clk) begin
      if (reset | power_on_reset) begin
         mem_valid_q      <= 1'b0;
         mem_addr_q       <= 32'h0000_0000;
         mem_hit_ext_q    <= 1'b0;
         mem_hit_onchip_q <= 1'b0;
      end else begin
         mem_valid_q      <= fetch_valid;
         mem_addr_q       <= fetch_out;
         mem_hit_ext_q    <= fetch_valid & ext_hit;
         mem_hit_onchip_q <= fetch_valid & ~ext_hit & on_hit;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign s_axi_awready  = awready_q;
   assign s_axi_wready   = wready_q;
   assign s_axi_bvalid   = bvalid_q;
   assign s_axi_bresp    = bresp_q;
   assign s_axi_arready  = arready_q;
   assign s_axi_rvalid   = rvalid_q;
   assign s_axi_rdata    = rdata_q;
   assign s_axi_rresp    = rresp_q;
   assign mem_valid      = mem_valid_q;
   assign mem_addr       = mem_addr_q;
   assign mem_hit_ext    = mem_hit_ext_q;
   assign mem_hit_onchip = mem_hit_onchip_q;

endmodule

`default_nettype wire

// File: crm_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// core fetch port: one fetch per request, launched on the clock
// ************************************************************
module crm_core_model (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        req,
   input  wire logic [31:0] req_addr,
   output logic             fetch_valid,
   output logic [31:0]      fetch_addr
);
   always_ff @(posedge clk) begin
      fetch_valid <= req & ~reset;
      // between fetches the address is not held, so a stale value cannot pass for a good one
      if (reset) begin
         fetch_addr <= 32'h0000_0000;
      end else begin
         fetch_addr <= req ? req_addr : ~fetch_addr;
      end
   end
endmodule
`default_nettype wire

// File: crm_remap_sva.sv
`timescale 1ns/100ps
`default_nettype none
module crm_remap_sva
   import crm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        power_on_reset,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic        fetch_valid,
   input  wire logic [31:0] fetch_addr,
   input  wire logic        mem_valid,
   input  wire logic [31:0] mem_addr,
   input  wire logic        mem_hit_ext,
   input  wire logic        mem_hit_onchip
);
   logic [31:0] rd_addr_q;
   logic        rst_seen_q;
   always_ff @(posedge clk) begin
      rst_seen_q <= reset | power_on_reset;
      if (s_axi_arvalid && s_axi_arready) begin
         rd_addr_q <= s_axi_araddr;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset || power_on_reset);
   // ************************************************************
   // checks
   // ************************************************************
   chk_fetch_pipe: assert property (!rst_seen_q |-> mem_valid == $past(fetch_valid))
      else $error("memory valid does not follow fetch valid");
   chk_pass_through: assert property (mem_valid && !mem_hit_ext && !mem_hit_onchip
      |-> mem_addr == $past(fetch_addr))
      else $error("miss address altered");
   chk_word_field: assert property (mem_hit_ext || mem_hit_onchip
      |-> ((mem_addr ^ $past(fetch_addr)) & 32'hFFFF_C003) == 32'h0)
      else $error("hit changed bits outside the word field");
   chk_ext_fixed: assert property (mem_hit_ext |-> mem_valid && mem_addr[31:25] == 7'h0B)
      else $error("external hit outside fixed base");
   chk_onchip_fixed: assert property (mem_hit_onchip |-> !mem_hit_ext && mem_addr[31:24] == 8'h00)
      else $error("on-chip hit outside fixed base");
   chk_rsvd_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[RSVD_BIT])
      else $error("reserved bit read as one");
   chk_ext_base_rd: assert property (s_axi_rvalid &&
      (rd_addr_q == EXT_REMAP_ADDR || rd_addr_q == EXT_ACTIVE_ADDR)
      |-> s_axi_rdata[31:25] == 7'h0B && s_axi_rdata[17:16] == 2'h0)
      else $error("external base fixed bits wrong");
   chk_onchip_base_rd: assert property (s_axi_rvalid &&
      (rd_addr_q == ONCHIP_REMAP_ADDR || rd_addr_q == ONCHIP_ACTIVE_ADDR)
      |-> s_axi_rdata[31:24] == 8'h00)
      else $error("on-chip base fixed bits wrong");
   chk_err_rdata: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("refused read returned data");
   chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   cov_ext_hit: cover property (mem_hit_ext);
   cov_onchip_hit: cover property (mem_hit_onchip);
   cov_refused: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
   cov_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind crm_remap_ctrl crm_remap_sva u_crm_remap_sva (.clk, .reset, .power_on_reset, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .fetch_valid, .fetch_addr, .mem_valid, .mem_addr, .mem_hit_ext, .mem_hit_onchip);
`default_nettype wire

// File: cache_region_remap_test.sv
`timescale 1ns/100ps
`default_nettype none
module cache_region_remap_test;
   import crm_pkg::*;
   typedef struct packed {logic [31:0] a; logic [31:0] x; logic e; logic o;} crm_row_t;
   logic        clk, reset, power_on_reset, req, slow_ready;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        fetch_valid, mem_valid, mem_hit_ext, mem_hit_onchip;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, fetch_addr, mem_addr, req_addr;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   int          bad_count, samples_checked, cycles;
   crm_row_t    rows [7] = '{'{32'h1620_0004, 32'h1620_0044, 1'b1, 1'b0}, '{32'h1623_FFFC, 32'h1623_C03C, 1'b1, 1'b0},
      '{32'h1624_0000, 32'h1624_0000, 1'b0, 1'b0}, '{32'h0040_0008, 32'h0040_000C, 1'b0, 1'b1},
      '{32'h0040_FFFC, 32'h0040_C000, 1'b0, 1'b1}, '{32'h0041_0000, 32'h0041_0000, 1'b0, 1'b0},
      '{32'h003F_FFFC, 32'h003F_FFFC, 1'b0, 1'b0}};
   crm_remap_ctrl u_crm_remap_ctrl (.clk, .reset, .power_on_reset, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .fetch_valid, .fetch_addr, .mem_valid, .mem_addr, .mem_hit_ext, .mem_hit_onchip);
   crm_core_model u_crm_core_model (.clk, .reset, .req, .req_addr, .fetch_valid, .fetch_addr);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ************************************************************
   // helpers
   // ************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= ~slow_ready;
      while (!done) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            chk({30'h0, s_axi_bresp}, {30'h0, er});
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end else if (s_axi_bvalid) begin
            // a late ready makes the response stand for a cycle
            s_axi_bready <= 1'b1;
         end
      end
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= ~slow_ready;
      while (!done) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            chk(s_axi_rdata, ed);
            chk({30'h0, s_axi_rresp}, {30'h0, er});
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end else if (s_axi_rvalid) begin
            s_axi_rready <= 1'b1;
         end
      end
   endtask
   task automatic fe(input logic [31:0] a, input logic [31:0] x, input logic e, input logic o);
      @(posedge clk);
      req <= 1'b1;
      req_addr <= a;
      @(posedge clk);
      req <= 1'b0;
      @(posedge clk);
      #1;
      chk({31'h0, mem_valid}, 32'h1);
      chk(mem_addr, x);
      chk({30'h0, mem_hit_ext, mem_hit_onchip}, {30'h0, e, o});
   endtask
   task automatic sw_reset();
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         bad_count++;
         results();
      end
   end
   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      logic [31:0] ext_sz, on_sz;
      {reset, power_on_reset, req, req_addr, s_axi_awprot, s_axi_arprot} = {1'b1, 1'b1, 1'b0, 32'h0, 6'h0};
      {slow_ready, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = {96'h0, 4'h0};
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      power_on_reset <= 1'b0;
      rd(EXT_REMAP_ADDR, 32'h1600_0006, RESP_OKAY);
      rd(ONCHIP_REMAP_ADDR, 32'h00A0_0006, RESP_OKAY);
      $display("test reset_values done");
      wr(EXT_REMAP_ADDR, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      rd(EXT_REMAP_ADDR, 32'h17FC_FFF7, RESP_OKAY);
      wr(ONCHIP_REMAP_ADDR, 32'hFFFF_FF1F, 4'h1, RESP_OKAY);
      rd(ONCHIP_REMAP_ADDR, 32'h00A0_0017, RESP_OKAY);
      slow_ready = 1'b1;
      wr(EXT_ACTIVE_ADDR, 32'h0, 4'hF, RESP_SLVERR);
      rd(EXT_ACTIVE_ADDR, 32'h1600_0006, RESP_OKAY);
      slow_ready = 1'b0;
      rd(ONCHIP_ACTIVE_ADDR, 32'h00A0_0006, RESP_OKAY);
      wr(32'h1A0C_0060, 32'h1, 4'hF, RESP_SLVERR);
      rd(32'h1A0C_0060, 32'h0, RESP_SLVERR);
      fe(32'h1600_0004, 32'h1600_0004, 1'b1, 1'b0);
      sw_reset();
      rd(EXT_REMAP_ADDR, 32'h17FC_FFF7, RESP_OKAY);
      rd(EXT_ACTIVE_ADDR, 32'h17FC_FFF7, RESP_OKAY);
      fe(32'h17FC_0008, 32'h17FC_0004, 1'b1, 1'b0);
      $display("test fixed_bits_and_pending done");
      for (int c = 0; c < 8; c++) begin
         // the external base sits on a 32 MB boundary and the on-chip base on a 512 kB one, so they suit every span code
         wr(EXT_REMAP_ADDR, {16'h1600, 13'h0, 3'(c)}, 4'hF, RESP_OKAY);
         wr(ONCHIP_REMAP_ADDR, {16'h0080, 13'h0, 3'(c)}, 4'hF, RESP_OKAY);
         sw_reset();
         ext_sz = 32'h0200_0000 >> c;
         on_sz = 32'h0008_0000 >> ((c < 4) ? 0 : c - 4);
         fe(32'h1600_0000 + ext_sz - 4, 32'h1600_0000 + ext_sz - 4, 1'b1, 1'b0);
         fe(32'h1600_0000 + ext_sz, 32'h1600_0000 + ext_sz, 1'b0, 1'b0);
         fe(32'h0080_0000 + on_sz - 4, 32'h0080_0000 + on_sz - 4, 1'b0, 1'b1);
         fe(32'h0080_0000 + on_sz, 32'h0080_0000 + on_sz, 1'b0, 1'b0);
      end
      $display("test span_codes done");
      wr(EXT_REMAP_ADDR, 32'h1620_0107, 4'hF, RESP_OKAY);
      wr(ONCHIP_REMAP_ADDR, 32'h0040_0017, 4'hF, RESP_OKAY);
      sw_reset();
      foreach (rows[i]) fe(rows[i].a, rows[i].x, rows[i].e, rows[i].o);
      repeat (2) @(posedge clk);
      #1;
      chk({29'h0, mem_valid, mem_hit_ext, mem_hit_onchip}, 32'h0);
      $display("test translation_rows done");
      @(posedge clk);
      power_on_reset <= 1'b1;
      @(posedge clk);
      power_on_reset <= 1'b0;
      rd(EXT_REMAP_ADDR, 32'h1600_0006, RESP_OKAY);
      rd(ONCHIP_ACTIVE_ADDR, 32'h00A0_0006, RESP_OKAY);
      $display("test power_on done");
      results();
   end
endmodule
`default_nettype wire
